// >>> pin_function_select_regs.vh
// Purpose: register offsets, reset values and field positions for the pin function selector
// Assumes: AHB-Lite word access, one register per aligned word
// Notes:   the variant codes pick which family member the selector logic behaves as
`ifndef PIN_FUNCTION_SELECT_REGS_VH
`define PIN_FUNCTION_SELECT_REGS_VH

// ================
// register byte offsets
`define OFS_PORTA_SEL     8'h00
`define OFS_PORTB_SEL     8'h04
`define OFS_PORTC_SEL     8'h08
`define OFS_PORTD_SEL     8'h0C
`define OFS_PORTE_SEL     8'h10
`define OFS_SPECIAL_SEL   8'h14
`define OFS_EXT_SEL       8'h18
`define OFS_VARIANT       8'h1C

// ================
// reset values
`define RST_PORTA_SEL     8'h00
`define RST_PORTB_SEL     8'h00
`define RST_PORTC_SEL     8'h00
`define RST_PORTD_SEL     8'hFF
`define RST_PORTE_SEL     8'hFF
`define RST_SPECIAL_SEL   8'h00
`define RST_EXT_SEL       8'h00

// ================
// implemented-bit masks
`define MASK_PORTC_LARGE  8'h78
`define MASK_PORTB_SMALL  8'h0F
`define MASK_EXT_SEL      8'h3F

// ================
// extension register field positions
`define EXT_PB6           1
`define EXT_PB7           2
`define EXT_PB5           3
`define EXT_PB4           4

// special select: pd7..pd4 timer choice in bits 3..0, pd2 choice in bit 7 (small)
`define SPC_PD2_SMALL     7

// ================
// pad function codes
`define FN_GPIO           3'h0
`define FN_ANALOG         3'h1
`define FN_TIMER          3'h2
`define FN_ALT            3'h3
`define FN_REF            3'h4
`define FN_OSC            3'h5
`define FN_SEGMENT        3'h6
`define FN_TIMER_INV      3'h7

// ================
// variants
`define VAR_LARGE         2'h0
`define VAR_MID           2'h1
`define VAR_SMALL         2'h2

`endif

// >>> pin_function_select.v
// Purpose: software-programmable pin function selection for ports A..E
// Assumes: single AHB-Lite master, word transfers, 40 MHz hclk
// Notes:   pad data/enables are registered; a selector write takes effect next cycle
//
// How it works
// RQ1 - mid variants: PA5 code 10 std timer out1, 11 serial clock, else GPIO.
// RQ2 - mid variants: PA3 code 10 std timer out0, 11 serial data in, else GPIO.
// RQ3 - mid variants: PA1 code 10 compact timer out1, 11 serial data out, else GPIO.
// RQ4 - large: PB7 by {sel7,ext}: GPIO, analog2, inverted ptimer1, uart tx.
// RQ5 - large: PB6 by {sel6,ext}: GPIO, analog1, ptimer1, uart rx.
// RQ6 - large: PB5 by {ext,sel5}: GPIO, inverted ptimer0, reference out, analog0.
// RQ7 - large: PB4 by {ext,sel4}: GPIO, ptimer0, reference in, GPIO.
// RQ8 - PB3/PB2 go to low-speed crystal only for code 11.
// RQ9 - PB1/PB0 go to high-speed oscillator only for code 11.
// RQ10 - small variant: port B bits 7..4 unimplemented, read zero.
// RQ11 - mid variants: PB7..4 bit set gives inv timer1, timer1, inv timer0, timer0.
// RQ12 - large: PC6..3 give analog 11..8; other port C bits read zero.
// RQ13 - large: PD7..4 set give segment or periodic timer via special register.
// RQ14 - large: PD3..0 clear give GPIO with timer clock or interrupt inputs, set give segments.
// RQ15 - small: PD2 set gives segment 2 or compact timer out2.
// RQ16 - large: PE bit n set gives segment 8+n.
// RQ17 - reset: port D and E selectors all ones, port B and C zero.
// RQ18 - PD7 special bit 3: 0 segment 7, 1 inverted ptimer1.
// RQ19 - only selected function drives or samples a pad; change next cycle.
// RQ20 - implemented selector bits read back the last written value; a read issued in that write's data phase gets the old value.
//
// Our own choices: register access over AHB-Lite and the register offsets.
`timescale 1ns/1ps
`include "pin_function_select_regs.vh"

module pin_function_select (
   // clock and reset
   input  wire        hclk,
   input  wire        hresetn,
   // ahb-lite slave
   input  wire        hsel,
   input  wire [7:0]  haddr,
   input  wire [1:0]  htrans,
   input  wire        hwrite,
   input  wire [2:0]  hsize,
   input  wire [31:0] hwdata,
   input  wire        hready,
   output reg  [31:0] hrdata,
   output reg         hreadyout,
   output reg         hresp,
   // variant strap
   input  wire [1:0]  variant,
   // gpio side, 40 pads (A..E)
   input  wire [39:0] gpio_out,
   input  wire [39:0] gpio_oe,
   output reg  [39:0] gpio_in,
   // functions that may drive a pad
   input  wire [39:0] seg_out,
   input  wire [3:0]  ptimer_out,
   input  wire [1:0]  std_timer_out,
   input  wire [2:0]  compact_timer_out,
   input  wire        sck_out,
   input  wire        sdo_out,
   input  wire        uart_tx,
   input  wire        ref_out,
   // pads
   input  wire [39:0] pad_in,
   output reg  [39:0] pad_out,
   output reg  [39:0] pad_oe,
   // function inputs, inactive when deselected
   output reg  [11:0] analog_en,
   output reg         sck_in,
   output reg         sdi_in,
   output reg         uart_rx,
   output reg         reference_in_en,
   output reg         low_speed_crystal_en,
   output reg         high_speed_osc_en,
   output reg         periodic_timer_clk_in,
   output reg         std_timer_clk_in,
   output reg         compact_timer_clk_in,
   output reg         ext_interrupt_1
);

   // ================
   // registers
   reg  [7:0]  porta_selector_r;
   reg  [7:0]  portb_selector_r;
   reg  [7:0]  portc_selector_r;
   reg  [7:0]  portd_selector_r;
   reg  [7:0]  porte_selector_r;
   reg  [7:0]  special_r;
   reg  [7:0]  extension_select_reg_r;
   reg  [1:0]  variant_r;
   reg         var_taken_r;
   reg  [1:0]  var_wait_r;
   reg  [1:0]  var_s1_r;
   reg  [1:0]  var_s2_r;
   reg  [39:0] pad_s1_r;
   reg  [39:0] pad_s2_r;
   reg         wr_pend_r;
   reg  [7:0]  wr_addr_r;
   reg  [2:0]  fn_a_pin;

   reg  [39:0] pad_out_nxt;
   reg  [39:0] pad_oe_nxt;
   reg  [39:0] sel_own;
   reg  [7:0]  pb_mask;
   reg  [7:0]  pc_mask;
   reg  [31:0] rd_nxt;
   wire [7:0]  pb_ext;
   integer     i;

   // ================
   // helpers
   function [2:0] mid_pa;
      input [1:0] code;
      begin
         mid_pa = code[1] ? (code[0] ? `FN_ALT : `FN_TIMER) : `FN_GPIO;
      end
   endfunction

   function [7:0] wmask;
      input [7:0] a;
      input [1:0] v;
      begin
         if (a == `OFS_PORTB_SEL && v == `VAR_SMALL) begin
            wmask = `MASK_PORTB_SMALL; // RQ10
         end else if (a == `OFS_PORTC_SEL) begin
            wmask = `MASK_PORTC_LARGE; // RQ12
         end else if (a == `OFS_EXT_SEL) begin
            wmask = `MASK_EXT_SEL;
         end else begin
            wmask = 8'hFF;
         end
      end
   endfunction

   // ================
   // bus slave: zero-wait writes, registered reads
   wire req = hsel && hready && htrans[1];

   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         porta_selector_r       <= `RST_PORTA_SEL;
         portb_selector_r       <= `RST_PORTB_SEL; // RQ17
         portc_selector_r       <= `RST_PORTC_SEL; // RQ17
         portd_selector_r       <= `RST_PORTD_SEL; // RQ17
         porte_selector_r       <= `RST_PORTE_SEL; // RQ17
         special_r              <= `RST_SPECIAL_SEL;
         extension_select_reg_r <= `RST_EXT_SEL;
         wr_pend_r              <= 1'b0;
         wr_addr_r              <= 8'h00;
         hrdata                 <= 32'h0000_0000;
         hreadyout              <= 1'b1;
         hresp                  <= 1'b0;
      end else begin
         wr_pend_r <= req && hwrite;
         if (req) begin
            wr_addr_r <= {haddr[7:2], 2'b00};
         end
         if (req && !hwrite) begin
            hrdata <= rd_nxt;
         end
         // data phase of a write: store masked bits, RQ20
         if (wr_pend_r) begin
            case (wr_addr_r)
               `OFS_PORTA_SEL:   porta_selector_r <= hwdata[7:0];
               `OFS_PORTB_SEL:   portb_selector_r <= hwdata[7:0] & wmask(wr_addr_r, variant_r);
               `OFS_PORTC_SEL:   portc_selector_r <= hwdata[7:0] & wmask(wr_addr_r, variant_r);
               `OFS_PORTD_SEL:   portd_selector_r <= hwdata[7:0];
               `OFS_PORTE_SEL:   porte_selector_r <= hwdata[7:0];
               `OFS_SPECIAL_SEL: special_r <= hwdata[7:0];
               `OFS_EXT_SEL:     extension_select_reg_r <= hwdata[7:0] & `MASK_EXT_SEL;
               default: ;
            endcase
         end
      end
   end

   always @* begin
      case ({haddr[7:2], 2'b00})
         `OFS_PORTA_SEL:   rd_nxt = {24'h000000, porta_selector_r};
         `OFS_PORTB_SEL:   rd_nxt = {24'h000000, portb_selector_r}; // RQ20
         `OFS_PORTC_SEL:   rd_nxt = {24'h000000, portc_selector_r};
         `OFS_PORTD_SEL:   rd_nxt = {24'h000000, portd_selector_r};
         `OFS_PORTE_SEL:   rd_nxt = {24'h000000, porte_selector_r};
         `OFS_SPECIAL_SEL: rd_nxt = {24'h000000, special_r};
         `OFS_EXT_SEL:     rd_nxt = {24'h000000, extension_select_reg_r};
         `OFS_VARIANT:     rd_nxt = {30'h00000000, variant_r};
         default:          rd_nxt = 32'h0000_0000;
      endcase
   end

   // ================
   // strap capture after reset release, through two flops
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         var_s1_r    <= 2'h0;
         var_s2_r    <= 2'h0;
         variant_r   <= `VAR_LARGE;
         var_taken_r <= 1'b0;
         var_wait_r  <= 2'h0;
      end else begin
         var_s1_r <= variant;
         var_s2_r <= var_s1_r;
         // wait until the strap has passed both flops
         if (var_wait_r != 2'h2) begin
            var_wait_r <= var_wait_r + 2'h1;
         end else if (!var_taken_r) begin
            variant_r   <= var_s2_r;
            var_taken_r <= 1'b1;
         end
      end
   end

   // ================
   // pad input synchroniser
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pad_s1_r <= 40'h00_0000_0000;
         pad_s2_r <= 40'h00_0000_0000;
      end else begin
         pad_s1_r <= pad_in;
         pad_s2_r <= pad_s1_r;
      end
   end

   // ================
   // pad mux; index = port*8 + pin, A=0 .. E=4
   assign pb_ext = extension_select_reg_r;

   always @* begin
      pad_out_nxt = gpio_out;
      pad_oe_nxt  = gpio_oe;
      sel_own     = 40'h00_0000_0000;
      pb_mask     = 8'h00;
      pc_mask     = 8'h00;
      fn_a_pin    = `FN_GPIO;
      // port A, mid variants
      if (variant_r == `VAR_MID) begin
         fn_a_pin = mid_pa(porta_selector_r[5:4]); // RQ1
         if (fn_a_pin != `FN_GPIO) begin
            sel_own[5] = 1'b1;
            pad_oe_nxt[5] = 1'b1;
            pad_out_nxt[5] = (fn_a_pin == `FN_TIMER) ? std_timer_out[1] : sck_out;
         end
         if (mid_pa(porta_selector_r[3:2]) == `FN_TIMER) begin // RQ2
            sel_own[3] = 1'b1;
            pad_oe_nxt[3] = 1'b1;
            pad_out_nxt[3] = std_timer_out[0];
         end else if (mid_pa(porta_selector_r[3:2]) == `FN_ALT) begin
            sel_own[3] = 1'b1;
            pad_oe_nxt[3] = 1'b0;
         end
         if (mid_pa(porta_selector_r[1:0]) != `FN_GPIO) begin // RQ3
            sel_own[1] = 1'b1;
            pad_oe_nxt[1] = 1'b1;
            pad_out_nxt[1] = porta_selector_r[0] ? sdo_out : compact_timer_out[1];
         end
      end
      // port B oscillator pairs
      if (portb_selector_r[3:2] == 2'b11) begin
         pb_mask[3:2] = 2'b11; // RQ8
      end
      if (portb_selector_r[1:0] == 2'b11) begin
         pb_mask[1:0] = 2'b11; // RQ9
      end
      // port B upper pins
      if (variant_r == `VAR_LARGE) begin
         case ({portb_selector_r[7], pb_ext[`EXT_PB7]}) // RQ4
            2'b01:   begin pb_mask[7] = 1'b1; pad_oe_nxt[15] = 1'b0; end
            2'b10:   begin pb_mask[7] = 1'b1; pad_oe_nxt[15] = 1'b1;
                           pad_out_nxt[15] = ptimer_out[3]; end
            2'b11:   begin pb_mask[7] = 1'b1; pad_oe_nxt[15] = 1'b1;
                           pad_out_nxt[15] = uart_tx; end
            default: ;
         endcase
         case ({portb_selector_r[6], pb_ext[`EXT_PB6]}) // RQ5
            2'b01:   begin pb_mask[6] = 1'b1; pad_oe_nxt[14] = 1'b0; end
            2'b10:   begin pb_mask[6] = 1'b1; pad_oe_nxt[14] = 1'b1;
                           pad_out_nxt[14] = ptimer_out[2]; end
            2'b11:   begin pb_mask[6] = 1'b1; pad_oe_nxt[14] = 1'b0; end
            default: ;
         endcase
         case ({pb_ext[`EXT_PB5], portb_selector_r[5]}) // RQ6
            2'b01:   begin pb_mask[5] = 1'b1; pad_oe_nxt[13] = 1'b1;
                           pad_out_nxt[13] = ptimer_out[1]; end
            2'b10:   begin pb_mask[5] = 1'b1; pad_oe_nxt[13] = 1'b1;
                           pad_out_nxt[13] = ref_out; end
            2'b11:   begin pb_mask[5] = 1'b1; pad_oe_nxt[13] = 1'b0; end
            default: ;
         endcase
         case ({pb_ext[`EXT_PB4], portb_selector_r[4]}) // RQ7
            2'b01:   begin pb_mask[4] = 1'b1; pad_oe_nxt[12] = 1'b1;
                           pad_out_nxt[12] = ptimer_out[0]; end
            2'b10:   begin pb_mask[4] = 1'b1; pad_oe_nxt[12] = 1'b0; end
            default: ;
         endcase
         pc_mask = portc_selector_r & `MASK_PORTC_LARGE; // RQ12
      end else if (variant_r == `VAR_MID) begin
         for (i = 4; i < 8; i = i + 1) begin
            if (portb_selector_r[i]) begin // RQ11
               pb_mask[i] = 1'b1;
               pad_oe_nxt[8+i] = 1'b1;
               pad_out_nxt[8+i] = ptimer_out[i-4];
            end
         end
      end
      for (i = 0; i < 4; i = i + 1) begin
         if (pb_mask[i]) begin
            pad_oe_nxt[8+i] = 1'b0;
         end
      end
      for (i = 0; i < 8; i = i + 1) begin
         sel_own[8+i]  = pb_mask[i];
         sel_own[16+i] = pc_mask[i];
         if (pc_mask[i]) begin
            pad_oe_nxt[16+i] = 1'b0;
         end
      end
      // port D segments or periodic timer outputs
      for (i = 0; i < 8; i = i + 1) begin
         if (portd_selector_r[i]) begin // RQ13 RQ14
            sel_own[24+i] = 1'b1;
            pad_oe_nxt[24+i] = 1'b1;
            pad_out_nxt[24+i] = seg_out[i];
            if (i >= 4 && special_r[i-4]) begin
               pad_out_nxt[24+i] = ptimer_out[i-4]; // RQ18
            end
         end
      end
      if (variant_r == `VAR_SMALL && portd_selector_r[2] &&
          special_r[`SPC_PD2_SMALL]) begin
         pad_out_nxt[26] = compact_timer_out[2]; // RQ15
      end
      // port E segments 8..15
      for (i = 0; i < 8; i = i + 1) begin
         if (porte_selector_r[i]) begin // RQ16
            sel_own[32+i] = 1'b1;
            pad_oe_nxt[32+i] = 1'b1;
            pad_out_nxt[32+i] = seg_out[8+i];
         end
      end
   end

   // ================
   // registered outputs; functions see inactive inputs when not selected
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pad_out               <= 40'h00_0000_0000;
         pad_oe                <= 40'h00_0000_0000;
         gpio_in               <= 40'h00_0000_0000;
         analog_en             <= 12'h000;
         sck_in                <= 1'b0;
         sdi_in                <= 1'b0;
         uart_rx               <= 1'b1;
         reference_in_en       <= 1'b0;
         low_speed_crystal_en  <= 1'b0;
         high_speed_osc_en     <= 1'b0;
         periodic_timer_clk_in <= 1'b0;
         std_timer_clk_in      <= 1'b0;
         compact_timer_clk_in  <= 1'b0;
         ext_interrupt_1       <= 1'b0;
      end else begin
         pad_out <= pad_out_nxt; // RQ19
         pad_oe  <= pad_oe_nxt;
         gpio_in <= pad_s2_r & ~sel_own;
         sck_in  <= (variant_r == `VAR_MID) && (porta_selector_r[5:4] == 2'b11) && pad_s2_r[5];
         sdi_in  <= (variant_r == `VAR_MID) && (porta_selector_r[3:2] == 2'b11) && pad_s2_r[3];
         uart_rx <= ((variant_r == `VAR_LARGE) &&
                     ({portb_selector_r[6], pb_ext[`EXT_PB6]} == 2'b11)) ? pad_s2_r[14] : 1'b1;
         analog_en <= {pc_mask[6:3],
                       1'b0, 1'b0, 1'b0, 1'b0, 1'b0,
                       (variant_r == `VAR_LARGE) && !portb_selector_r[7] && pb_ext[`EXT_PB7],
                       (variant_r == `VAR_LARGE) && !portb_selector_r[6] && pb_ext[`EXT_PB6],
                       (variant_r == `VAR_LARGE) && pb_ext[`EXT_PB5] && portb_selector_r[5]};
         reference_in_en      <= (variant_r == `VAR_LARGE) &&
                                 ({pb_ext[`EXT_PB4], portb_selector_r[4]} == 2'b10);
         low_speed_crystal_en <= pb_mask[3];
         high_speed_osc_en    <= pb_mask[1];
         periodic_timer_clk_in <= !portd_selector_r[3] && pad_s2_r[27]; // RQ14
         std_timer_clk_in      <= !portd_selector_r[2] && pad_s2_r[26];
         compact_timer_clk_in  <= !portd_selector_r[1] && pad_s2_r[25];
         ext_interrupt_1       <= !portd_selector_r[0] && pad_s2_r[24];
      end
   end

endmodule

// >>> pin_function_select_props.sv
// Purpose: bus and pad ownership checks for pin_function_select
// Assumes: one master, hready looped back from hreadyout
// Notes:   keeps its own copy of the port E selector
`timescale 1ns/1ps
module pin_function_select_props (
   // clock and reset
   input wire        hclk,
   input wire        hresetn,
   // bus
   input wire        hsel,
   input wire [7:0]  haddr,
   input wire [1:0]  htrans,
   input wire        hwrite,
   input wire [31:0] hwdata,
   input wire        hready,
   input wire [31:0] hrdata,
   input wire        hreadyout,
   input wire        hresp,
   // pads and functions
   input wire [39:0] gpio_oe,
   input wire [39:0] gpio_in,
   input wire [39:0] pad_oe,
   input wire [11:0] analog_en,
   input wire        low_speed_crystal_en
);
   // ================
   // port E shadow; live_r skips reset-time samples
   wire       take = hsel && hready && htrans[1];
   wire       rd   = take && !hwrite;
   reg        wr_e_r;
   reg  [7:0] pe_r;
   reg  [1:0] live_r;
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_e_r <= 1'b0;
         pe_r   <= 8'hFF;
         live_r <= 2'h0;
      end else begin
         wr_e_r <= take && hwrite && haddr[7:2] == 6'h04;
         if (wr_e_r && hready)
            pe_r <= hwdata[7:0];
         if (live_r != 2'h3)
            live_r <= live_r + 2'h1;
      end
   end

   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   // ================
   // properties
   property p_ready;
      hreadyout && !hresp;
   endproperty
   a_ready: assert property (p_ready) else $error("slave stalled or not okay");
   property p_rd_upper;
      rd |=> hrdata[31:8] == 24'h0;
   endproperty
   a_rd_upper: assert property (p_rd_upper) else $error("upper read data set");
   property p_portc_mask;
      rd && haddr[7:2] == 6'h02 |=> (hrdata[7:0] & 8'h87) == 8'h00;
   endproperty
   a_portc_mask: assert property (p_portc_mask) else $error("port c hole set");
   property p_ext_mask;
      rd && haddr[7:2] == 6'h06 |-> ##1 hrdata[7:6] == 2'h0;
   endproperty
   a_ext_mask: assert property (p_ext_mask) else $error("extension hole set");
   property p_rd_hold;
      !$past(rd) |-> $stable(hrdata);
   endproperty
   a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
   property p_pe_oe;
      live_r == 2'h3 |-> pad_oe[39:32] == ($past(pe_r) | $past(gpio_oe[39:32]));
   endproperty
   a_pe_oe: assert property (p_pe_oe) else $error("port e drive wrong");
   property p_pe_in;
      live_r == 2'h3 |-> (gpio_in[39:32] & $past(pe_r)) == 8'h00;
   endproperty
   a_pe_in: assert property (p_pe_in) else $error("segment pad seen by gpio");
   property p_an_off;
      (analog_en[11:8] & pad_oe[22:19]) == 4'h0 && (analog_en[2:0] & pad_oe[15:13]) == 3'h0;
   endproperty
   a_an_off: assert property (p_an_off) else $error("analog pad driven");
   property p_xtal_off;
      low_speed_crystal_en |-> pad_oe[11:10] == 2'h0;
   endproperty
   a_xtal_off: assert property (p_xtal_off) else $error("crystal pad driven");
   c_wr_e: cover property (wr_e_r);
   c_an: cover property (analog_en != 12'h000);
   c_xtal: cover property (low_speed_crystal_en);
endmodule

bind pin_function_select pin_function_select_props i_props (
   .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
   .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
   .hreadyout(hreadyout), .hresp(hresp), .gpio_oe(gpio_oe), .gpio_in(gpio_in),
   .pad_oe(pad_oe), .analog_en(analog_en), .low_speed_crystal_en(low_speed_crystal_en)
);

// >>> pin_function_select_tb.sv
// Purpose: self-checking bench for pin_function_select
// Assumes: zero-wait slave, hready looped back from hreadyout
// Notes:   all three variants checked at pads and readback
`timescale 1ns/1ps
module pin_function_select_tb;
   // ================
   // stimulus, observation, model state
   logic        hclk, hresetn, hsel, hwrite, uart_tx, ref_out, sck_out, sdo_out;
   logic [1:0]  htrans, variant, std_timer_out;
   logic [2:0]  compact_timer_out;
   logic [3:0]  ptimer_out;
   logic [7:0]  haddr;
   logic [31:0] hwdata, lfsr, rd;
   logic [39:0] gpio_out, gpio_oe, seg_out, pad_in, e_out, e_oe, e_in, dc;
   logic [17:0] fn;
   logic [7:0]  sel [0:8];
   wire  [31:0] hrdata;
   wire  [39:0] gpio_in, pad_out, pad_oe;
   wire  [11:0] analog_en;
   wire         hreadyout, hresp, sck_in, sdi_in, uart_rx, reference_in_en;
   wire         low_speed_crystal_en, high_speed_osc_en, periodic_timer_clk_in;
   wire         std_timer_clk_in, compact_timer_clk_in, ext_interrupt_1;
   int          fails, checked;

   pin_function_select i_pin_function_select (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .variant(variant),
      .gpio_out(gpio_out), .gpio_oe(gpio_oe), .gpio_in(gpio_in), .seg_out(seg_out),
      .ptimer_out(ptimer_out), .std_timer_out(std_timer_out),
      .compact_timer_out(compact_timer_out), .sck_out(sck_out), .sdo_out(sdo_out),
      .uart_tx(uart_tx), .ref_out(ref_out), .pad_in(pad_in), .pad_out(pad_out),
      .pad_oe(pad_oe), .analog_en(analog_en), .sck_in(sck_in), .sdi_in(sdi_in),
      .uart_rx(uart_rx), .reference_in_en(reference_in_en),
      .low_speed_crystal_en(low_speed_crystal_en), .high_speed_osc_en(high_speed_osc_en),
      .periodic_timer_clk_in(periodic_timer_clk_in), .std_timer_clk_in(std_timer_clk_in),
      .compact_timer_clk_in(compact_timer_clk_in), .ext_interrupt_1(ext_interrupt_1)
   );

   initial begin
      hclk = 1'b0;
      forever #12.5 hclk = ~hclk;
   end

   // ================
   // helpers
   function automatic logic [31:0] rnd();
      repeat (32) lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
      return lfsr;
   endfunction

   function automatic logic [7:0] msk(input int i);
      case (i)
         1: return (variant == 2'h2) ? 8'h0F : 8'hFF;
         2: return 8'h78;
         6: return 8'h3F;
         7, 8: return 8'h00;
         default: return 8'hFF;
      endcase
   endfunction

   task automatic wrap_up;
      if (fails == 0 && checked > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   task automatic chk(input logic [63:0] got, exp);
      checked++;
      if (got !== exp) begin
         fails++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic wait_rdy;
      for (int n = 0; n < 64; n++) begin
         @(posedge hclk);
         if (hreadyout === 1'b1)
            return;
      end
      fails++;
      wrap_up;
   endtask

   // single transfer; read data to rd
   task automatic bus(input logic w, input int i, input logic [31:0] d);
      hsel   <= 1'b1;
      htrans <= 2'h2;
      hwrite <= w;
      haddr  <= 8'(i * 4);
      wait_rdy;
      hsel   <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      wait_rdy;
      rd = hrdata;
   endtask

   task automatic wr(input int i, input logic [31:0] d);
      bus(1'b1, i, d);
      sel[i] = (d[7:0] & msk(i)) | (sel[i] & ~msk(i));
   endtask

   task automatic rchk(input int i);
      bus(1'b0, i, 32'h0);
      chk(rd, {24'h0, sel[i]});
   endtask

   task automatic stir;
      gpio_out <= 40'({rnd(), rnd()});
      gpio_oe  <= 40'({rnd(), rnd()});
      seg_out  <= 40'({rnd(), rnd()});
      pad_in   <= 40'({rnd(), rnd()});
      {ptimer_out, std_timer_out, compact_timer_out, uart_tx, ref_out, sck_out, sdo_out}
         <= 13'(rnd());
   endtask

   // ================
   // pad ownership model
   task automatic drv(input int p, input logic v);
      e_oe[p]  = 1'b1;
      e_out[p] = v;
      e_in[p]  = 1'b0;
   endtask

   task automatic inp(input int p, input int k);
      e_oe[p] = 1'b0;
      e_in[p] = 1'b0;
      fn[k]   = 1'b1;
   endtask

   task automatic model;
      logic [7:0] a, b, x;
      a = sel[0];
      b = sel[1];
      x = sel[6];
      {e_out, e_oe, e_in, dc, fn} = {gpio_out, gpio_oe, pad_in, 40'h0, 18'h0};
      if (variant == 2'h1) begin
         case (a[5:4])
            2'h2: drv(5, std_timer_out[1]);
            2'h3: inp(5, 17);
         endcase
         case (a[3:2])
            2'h2: drv(3, std_timer_out[0]);
            2'h3: inp(3, 16);
         endcase
         case (a[1:0])
            2'h2: drv(1, compact_timer_out[1]);
            2'h3: drv(1, sdo_out);
         endcase
         for (int p = 4; p < 8; p++)
            if (b[p])
               drv(8 + p, ptimer_out[p - 4]);
      end else if (variant == 2'h0) begin
         case ({b[7], x[2]})
            2'h1: inp(15, 2);
            2'h2: drv(15, ptimer_out[3]);
            2'h3: drv(15, uart_tx);
         endcase
         case ({b[6], x[1]})
            2'h1: inp(14, 1);
            2'h2: drv(14, ptimer_out[2]);
            2'h3: inp(14, 12);
            default: ;
         endcase
         case ({x[3], b[5]})
            2'h1: drv(13, ptimer_out[1]);
            2'h2: drv(13, ref_out);
            2'h3: inp(13, 0);
         endcase
         case ({x[4], b[4]})
            2'h1: drv(12, ptimer_out[0]);
            2'h2: inp(12, 13);
         endcase
         for (int p = 3; p < 7; p++)
            if (sel[2][p])
               inp(16 + p, 5 + p);
      end
      if (b[3:2] == 2'h3) begin
         inp(11, 14);
         inp(10, 14);
      end
      if (b[1:0] == 2'h3) begin
         inp(9, 15);
         inp(8, 15);
      end
      for (int p = 0; p < 8; p++) begin
         if (sel[3][p])
            drv(24 + p, (p > 3 && sel[5][p % 4]) ? ptimer_out[p % 4] : seg_out[p]);
         if (sel[4][p])
            drv(32 + p, seg_out[8 + p]);
      end
      if (variant == 2'h2 && sel[3][2] && sel[5][7])
         e_out[26] = compact_timer_out[2];
      // serial clock direction is left open, so that pad is not judged
      dc[5] = fn[17];
   endtask

   task automatic cmp;
      model;
      chk(pad_oe & ~dc, e_oe & ~dc);
      chk(pad_out & e_oe & ~dc, e_out & e_oe & ~dc);
      chk(gpio_in, e_in);
      chk(analog_en, fn[11:0]);
      chk({sck_in, uart_rx, sdi_in, reference_in_en, low_speed_crystal_en, high_speed_osc_en,
           periodic_timer_clk_in, std_timer_clk_in, compact_timer_clk_in, ext_interrupt_1},
          {fn[17] & pad_in[5], fn[12] ? pad_in[14] : 1'b1, fn[16] & pad_in[3], fn[13], fn[14],
           fn[15], ~sel[3][3:0] & pad_in[27:24]});
   endtask

   // ================
   // sequences
   task automatic start(input logic [1:0] v);
      hresetn <= 1'b0;
      variant <= v;
      stir;
      repeat (12) @(posedge hclk);
      hresetn <= 1'b1;
      repeat (4) @(posedge hclk);
      sel = '{8'h00, 8'h00, 8'h00, 8'hFF, 8'hFF, 8'h00, 8'h00, {6'h0, v}, 8'h00};
      for (int i = 0; i < 9; i++)
         rchk(i);
      wr(8, rnd());
      wr(7, rnd());
      rchk(8);
      rchk(7);
      cmp;
   endtask

   task automatic run;
      logic [31:0] d;
      repeat (40) begin
         stir;
         for (int i = 0; i < 7; i++)
            if (variant == 2'h0 || (i != 2 && i != 6)) begin
               d = rnd();
               if (i == 0)
                  d[7:6] = 2'h0;
               wr(i, d);
            end
         for (int i = 0; i < 7; i++)
            rchk(i);
         cmp;
      end
   endtask

   initial begin
      {hsel, hwrite, haddr, htrans, hwdata, variant} = '0;
      hresetn = 1'b0;
      fails = 0;
      checked = 0;
      lfsr = 32'hC75401D4;
      start(2'h0);
      run;
      start(2'h1);
      run;
      start(2'h2);
      stir;
      wr(1, 32'hFFFFFFFF);
      wr(5, 32'h80);
      rchk(1);
      cmp;
      wrap_up;
   end

   initial begin
      repeat (100000) @(posedge hclk);
      fails++;
      wrap_up;
   end
endmodule
